// >>> hdl/gpio_port_e.sv
/*
 * Four-pin bidirectional port with direction and analog-select registers,
 * reached over AHB-Lite. Pin 3 is input only and shares the master clear.
 * Assumes pin inputs already synchronous to clk.
 */
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Three bidirectional pins and input-only pin 3, one direction bit each in one shared direction register.
// - Direction bit one makes the pin an input, driver off.
// - Direction bit zero drives the pin's output latch.
// - Pin 3 is input only; its direction bit reads one.
// - Data reads return pin levels; writes update only the latch.
// - Writes store the written data straight to the latch; the pin sample is not used.
// - With master clear enabled, pin 3 reads zero.
// - Direction bits still control drivers on analog pins.
// - Analog-selected pins read zero through the data register.
// - Analog bits 2..0 map to pins 2..0; one means analog.
// - Data and direction bits 7..4 read zero.
// - Analog select bits 7..3 read zero.
// - Analog select does not affect digital output driving.
module gpio_port_e (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] pinIn,
    output logic [3:0] pinOut,
    output logic [3:0] pinOe,
    output logic [2:0] analogEnable
);
    reg_access_if regs ();

    logic [3:0] pinLatch;
    logic [2:0] direction;
    logic [2:0] analogSelect;
    logic masterClearPinEnable;
    logic [3:0] pinRead;
    logic [3:0] directionRead;
    logic [3:0] rmwValue;
    logic wrPinData;

    ahb_reg_slave busSlave (
        .clk(clk),
        .nrst(nrst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .regs(regs.slave)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_comb begin
        pinRead = pinIn;
        pinRead[2:0] = pinIn[2:0] & ~analogSelect;
        pinRead[gpio_port_pkg::INPUT_ONLY_POS] = pinIn[gpio_port_pkg::INPUT_ONLY_POS]
            & ~masterClearPinEnable;
    end

    assign directionRead = {1'b1, direction};

    assign wrPinData = regs.wrStrobe && (regs.wrOffset == gpio_port_pkg::PIN_DATA_OFFSET);

    // write value of port latch
    // Whole-word write replaces all bits; the pin sample is not used
    always_comb begin
        rmwValue = pinRead;
        rmwValue = regs.wrData[3:0];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinLatch <= gpio_port_pkg::PIN_LATCH_RESET;
        end else if (wrPinData) begin
            pinLatch <= rmwValue;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            direction <= gpio_port_pkg::DIRECTION_RESET[2:0];
        end else if (regs.wrStrobe && regs.wrOffset == gpio_port_pkg::DIRECTION_OFFSET) begin
            direction <= regs.wrData[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            analogSelect <= gpio_port_pkg::ANALOG_SELECT_RESET;
        end else if (regs.wrStrobe
            && regs.wrOffset == gpio_port_pkg::ANALOG_SELECT_OFFSET) begin
            analogSelect <= regs.wrData[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            masterClearPinEnable <= gpio_port_pkg::CONFIG_MCLR_RESET;
        end else if (regs.wrStrobe && regs.wrOffset == gpio_port_pkg::CONFIG_OFFSET) begin
            masterClearPinEnable <= regs.wrData[0];
        end
    end

    always_comb begin
        case (regs.rdOffset)
            gpio_port_pkg::PIN_DATA_OFFSET: regs.rdData = {28'h0, pinRead};
            gpio_port_pkg::DIRECTION_OFFSET: regs.rdData = {28'h0, directionRead};
            gpio_port_pkg::ANALOG_SELECT_OFFSET: regs.rdData = {29'h0, analogSelect};
            gpio_port_pkg::CONFIG_OFFSET: regs.rdData = {31'h0, masterClearPinEnable};
            default: regs.rdData = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinOe <= 4'h0;
            pinOut <= 4'h0;
            analogEnable <= gpio_port_pkg::ANALOG_SELECT_RESET;
        end else begin
            pinOe <= {1'b0, ~direction};
            pinOut <= {1'b0, pinLatch[2:0]};
            analogEnable <= analogSelect;
        end
    end

    // Decoded selects for the checks below
    logic rdPinData;
    logic rdDirection;
    logic rdAnalog;
    logic wrDirection;
    logic wrAnalog;

    assign rdPinData = regs.rdOffset == gpio_port_pkg::PIN_DATA_OFFSET;
    assign rdDirection = regs.rdOffset == gpio_port_pkg::DIRECTION_OFFSET;
    assign rdAnalog = regs.rdOffset == gpio_port_pkg::ANALOG_SELECT_OFFSET;
    assign wrDirection = regs.wrStrobe && regs.wrOffset == gpio_port_pkg::DIRECTION_OFFSET;
    assign wrAnalog = regs.wrStrobe && regs.wrOffset == gpio_port_pkg::ANALOG_SELECT_OFFSET;

    drive_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> pinOe == {1'b0, ~$past(direction)})
        else $error("pin enable mismatch");

    pin3_input_a: assert property (@(posedge clk) disable iff (!nrst)
        pinOe[3] == 1'b0)
        else $error("pin 3 driven");

    dir3_read_a: assert property (@(posedge clk) disable iff (!nrst)
        directionRead[3] == 1'b1)
        else $error("pin 3 direction not one");

    out_latch_a: assert property (@(posedge clk) disable iff (!nrst)
        pinOe[0] |-> pinOut[0] == $past(pinLatch[0]))
        else $error("out not latch");

    analog_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        analogSelect[1] |-> pinRead[1] == 1'b0)
        else $error("analog pin read");

    mclr_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        masterClearPinEnable |-> pinRead[3] == 1'b0)
        else $error("pin 3 not masked");

    latch_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wrPinData |=> pinLatch == $past(regs.wrData[3:0]))
        else $error("latch not written");

    upper_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        regs.rdData[31:4] == 28'h0)
        else $error("upper bits nonzero");

    analog_out_a: assert property (@(posedge clk) disable iff (!nrst)
        (!direction[2] && analogSelect[2]) |=> pinOe[2])
        else $error("analog gated out");

    drive_off_a: assert property (@(posedge clk) disable iff (!nrst)
        direction[0] |=> !pinOe[0])
        else $error("input pin driven");

    drive_on_a: assert property (@(posedge clk) disable iff (!nrst)
        !direction[1] |=> pinOe[1])
        else $error("output pin not driven");

    out_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> pinOut[2:0] == $past(pinLatch[2:0]))
        else $error("pin outputs not latch");

    pin3_out_a: assert property (@(posedge clk) disable iff (!nrst)
        pinOut[3] == 1'b0)
        else $error("pin 3 output set");

    dir_read_a: assert property (@(posedge clk) disable iff (!nrst)
        rdDirection |-> regs.rdData == {28'h0, 1'b1, direction})
        else $error("direction read wrong");

    data_read_a: assert property (@(posedge clk) disable iff (!nrst)
        rdPinData |-> regs.rdData[3:0] == (pinIn & {~masterClearPinEnable, ~analogSelect}))
        else $error("pin data read wrong");

    analog_read_a: assert property (@(posedge clk) disable iff (!nrst)
        rdAnalog |-> regs.rdData == {29'h0, analogSelect})
        else $error("analog select read wrong");

    dir_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wrDirection |=> direction == $past(regs.wrData[2:0]))
        else $error("direction not written");

    dir_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        !wrDirection |=> $stable(direction))
        else $error("direction changed unasked");

    data_only_a: assert property (@(posedge clk) disable iff (!nrst)
        wrPinData |=> $stable(direction) && $stable(analogSelect))
        else $error("data write touched control");

    latch_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !wrPinData |=> $stable(pinLatch))
        else $error("latch changed unasked");

    rmw_store_a: assert property (@(posedge clk) disable iff (!nrst)
        wrPinData |-> rmwValue == regs.wrData[3:0])
        else $error("stored value wrong");

    analog_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wrAnalog |=> analogSelect == $past(regs.wrData[2:0]))
        else $error("analog select not written");

    analog_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        !wrAnalog |=> $stable(analogSelect))
        else $error("analog select changed unasked");

    analog_pin_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> analogEnable == $past(analogSelect))
        else $error("analog enable wrong");

    analog_dir_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(analogSelect[1]) |-> pinOe[1] == !$past(direction[1]))
        else $error("analog pin driver wrong");

    analog_drive_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(analogSelect[0]) |-> pinOut[0] == $past(pinLatch[0]))
        else $error("analog pin output wrong");

    pin0_analog_a: assert property (@(posedge clk) disable iff (!nrst)
        rdPinData && analogSelect[0] |-> !regs.rdData[0])
        else $error("analog pin 0 read set");

    mclr_read_a: assert property (@(posedge clk) disable iff (!nrst)
        rdPinData && masterClearPinEnable |-> !regs.rdData[3])
        else $error("pin 3 read while masked");

    digital_read_a: assert property (@(posedge clk) disable iff (!nrst)
        rdPinData && !analogSelect[2] |-> regs.rdData[2] == pinIn[2])
        else $error("digital pin 2 read wrong");

    pin3_read_a: assert property (@(posedge clk) disable iff (!nrst)
        rdPinData && !masterClearPinEnable |-> regs.rdData[3] == pinIn[3])
        else $error("pin 3 read wrong");

endmodule

// >>> hdl/gpio_port_pkg.sv
/*
 * Shared constants for the four-pin general purpose port: register byte
 * offsets, field widths and positions, and reset values.
 * Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
 */
package gpio_port_pkg;
    localparam int PORT_WIDTH = 4;
    localparam int ANALOG_WIDTH = 3;
    localparam int INPUT_ONLY_POS = 3;
    localparam logic [7:0] PIN_DATA_OFFSET = 8'h00;
    localparam logic [7:0] DIRECTION_OFFSET = 8'h04;
    localparam logic [7:0] ANALOG_SELECT_OFFSET = 8'h08;
    localparam logic [7:0] CONFIG_OFFSET = 8'h0c;
    localparam logic [3:0] PIN_LATCH_RESET = 4'h0;
    localparam logic [3:0] DIRECTION_RESET = 4'hf;
    localparam logic [2:0] ANALOG_SELECT_RESET = 3'h7;
    localparam logic CONFIG_MCLR_RESET = 1'b0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> hdl/reg_access_if.sv
/*
 * Carries decoded register accesses from the bus slave to the port core.
 * Assumes one clock domain; strobes last one cycle.
 */
`timescale 1ns/1ps
interface reg_access_if;
    logic wrStrobe;
    logic [7:0] wrOffset;
    logic [31:0] wrData;
    logic [7:0] rdOffset;
    logic [31:0] rdData;
    modport slave (output wrStrobe, output wrOffset, output wrData, output rdOffset,
        input rdData);
    modport core (input wrStrobe, input wrOffset, input wrData, input rdOffset,
        output rdData);
endinterface

// >>> hdl/ahb_reg_slave.sv
/*
 * AHB-Lite slave: latches the address phase, registers read data at its end,
 * and issues a write strobe in the data phase. Zero wait states, always OKAY.
 * Assumes single whole-word transfers.
 */
`timescale 1ns/1ps
module ahb_reg_slave (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    reg_access_if.slave regs
);
    logic phaseWrite;
    logic [7:0] phaseOffset;
    logic takeAddr;

    assign takeAddr = hsel && hready && (htrans == gpio_port_pkg::HTRANS_NONSEQ);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phaseWrite <= 1'b0;
            phaseOffset <= 8'h00;
        end else begin
            phaseWrite <= takeAddr && hwrite;
            if (takeAddr) begin
                phaseOffset <= haddr[7:0];
            end
        end
    end

    assign regs.wrStrobe = phaseWrite;
    assign regs.wrOffset = phaseOffset;
    assign regs.wrData = hwdata;
    // Read data registered from address phase so hrdata is a flip-flop
    assign regs.rdOffset = haddr[7:0];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            hrdata <= 32'h0;
        end else if (takeAddr && !hwrite) begin
            hrdata <= regs.rdData;
        end
    end
endmodule

// >>> bench/pin_partner.sv
/*
 * Far side of the port pins: resolves each pin wire from the port's driver
 * and an outside level. Assumes the outside level comes from the bench.
 */
`timescale 1ns/1ps
module pin_partner (
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe,
    input wire logic [3:0] extLevel,
    output logic [3:0] pinIn
);
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// >>> bench/tb_top.sv
/*
 * Self-checking bench for the four-pin port: AHB-Lite master tasks and a
 * register model. Assumes zero-wait slave and one clock.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] extLevel = 4'h0;
    logic [31:0] hrdata, r;
    logic hreadyout, hresp;
    logic [3:0] pinIn, pinOut, pinOe, latch = 4'h0;
    logic [2:0] analogEnable, dir = 3'h7, ansel = 3'h7;
    logic mclr = 1'b0;
    logic [7:0] a;
    logic [31:0] d;
    logic w;
    int failCount = 0;
    int totalChecks = 0;
    int cycles = 0;
    int seed = 32'h6aab;
    always #2 clk = ~clk;
    gpio_port_e DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .analogEnable(analogEnable));
    pin_partner far (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        totalChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
        hsel <= 1'b1;
        haddr <= {24'h0, adr};
        hwrite <= wr;
        htrans <= gpio_port_pkg::HTRANS_NONSEQ;
        do begin @(posedge clk); end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= dat;
        do begin @(posedge clk); end while (hreadyout !== 1'b1);
        r = hrdata;
        check("hresp", 32'h0, 32'(hresp));
        if (wr) begin
            case (adr)
                gpio_port_pkg::PIN_DATA_OFFSET: latch = dat[3:0];
                gpio_port_pkg::DIRECTION_OFFSET: dir = dat[2:0];
                gpio_port_pkg::ANALOG_SELECT_OFFSET: ansel = dat[2:0];
                gpio_port_pkg::CONFIG_OFFSET: mclr = dat[0];
                default: ;
            endcase
        end
    endtask
    function automatic logic [31:0] expRead(input logic [7:0] adr);
        logic [3:0] lvl;
        lvl = {extLevel[3], (dir & extLevel[2:0]) | (~dir & latch[2:0])};
        case (adr)
            gpio_port_pkg::PIN_DATA_OFFSET: return {28'h0, lvl & {~mclr, ~ansel}};
            gpio_port_pkg::DIRECTION_OFFSET: return {28'h0, 1'b1, dir};
            gpio_port_pkg::ANALOG_SELECT_OFFSET: return {29'h0, ansel};
            gpio_port_pkg::CONFIG_OFFSET: return {31'h0, mclr};
            default: return 32'h0;
        endcase
    endfunction
    task automatic access(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
        bus(wr, adr, dat);
        if (!wr) check("read", expRead(adr), r);
        repeat (2) @(posedge clk);
        check("pinOe", {29'h0, ~dir}, 32'(pinOe));
        check("pinOut", {29'h0, latch[2:0]}, 32'(pinOut));
        check("analogEnable", {29'h0, ansel}, 32'(analogEnable));
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            report_and_stop;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 4; i++) access(1'b0, 8'(i * 4), 32'h0);
        $display("test reset values done");
        access(1'b1, gpio_port_pkg::DIRECTION_OFFSET, 32'h7);
        access(1'b1, gpio_port_pkg::ANALOG_SELECT_OFFSET, 32'h7);
        extLevel <= 4'h7;
        @(posedge clk);
        access(1'b0, gpio_port_pkg::PIN_DATA_OFFSET, 32'h0);
        $display("test analog inputs done");
        bus(1'b1, gpio_port_pkg::DIRECTION_OFFSET, 32'h0);
        bus(1'b0, gpio_port_pkg::DIRECTION_OFFSET, 32'h0);
        check("direction", 32'h8, r);
        $display("test back to back done");
        for (int i = 0; i < 80; i++) begin
            a = 8'(($random(seed) & 7) * 4);
            w = 1'($random(seed));
            d = $random(seed);
            extLevel <= 4'($random(seed));
            @(posedge clk);
            access(w, a, d);
        end
        $display("test random traffic done");
        report_and_stop;
    end
endmodule
